/* File: verilog/smc_pkg.sv */
// shared constants for the interrupt and safety configuration register
package smc_pkg;

  // ------------------------------------------------------------
  // register layout
  // ------------------------------------------------------------
  localparam int          CFG_W        = 8;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam int          BIT_KEYED_LP = 7;
  localparam int          BIT_PARITY   = 6;
  localparam int          BIT_LEVEL    = 5;
  localparam int          BIT_SHORT    = 4;
  localparam int          BIT_HALF_WD  = 3;
  localparam int          RES_HI       = 2;
  localparam int          RES_LO       = 0;
  localparam logic [2:0]  RES_LARGE    = 3'h4;
  localparam logic [2:0]  RES_MIDDLE   = 3'h5;
  localparam logic [2:0]  RES_SMALL    = 3'h6;

  // ------------------------------------------------------------
  // spi frame layout: write flag, address, parity, data
  // ------------------------------------------------------------
  localparam int          FRAME_W      = 16;
  localparam int          FB_WRITE     = 15;
  localparam int          FB_ADDR_HI   = 14;
  localparam int          FB_ADDR_LO   = 9;
  localparam int          FB_PARITY    = 8;
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  CFG_ADDR     = 6'h01;
  localparam logic [4:0]  BITS_FULL    = 5'h10;

  // ------------------------------------------------------------
  // resistor expectation and safe-mode variant codes
  // ------------------------------------------------------------
  localparam logic [1:0]  EXPECT_NONE  = 2'h0;
  localparam logic [1:0]  EXPECT_SMALL = 2'h1;
  localparam logic [1:0]  EXPECT_MID   = 2'h2;
  localparam logic [1:0]  EXPECT_LARGE = 2'h3;
  localparam logic [1:0]  SAFE_NONE    = 2'h0;
  localparam logic [1:0]  SAFE_ONE     = 2'h1;
  localparam logic [1:0]  SAFE_TWO     = 2'h2;
  localparam logic [1:0]  SAFE_THREE   = 2'h3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_MHZ      = 200;
  localparam int          PULSE_LONG_US  = 100;
  localparam int          PULSE_SHORT_US = 25;
  localparam int          PULSE_LONG_CYC  = PULSE_LONG_US * CLK_MHZ;
  localparam int          PULSE_SHORT_CYC = PULSE_SHORT_US * CLK_MHZ;
  localparam int          CNT_W        = 16;

  // interrupt output states
  typedef enum logic [2:0] {
    INT_IDLE  = 3'b001,
    INT_PULSE = 3'b010,
    INT_LEVEL = 3'b100
  } smc_int_e;

endpackage

/* File: verilog/smc_top.sv */
// configuration register with spi access, interrupt shaping and safe-mode decode
`timescale 1ns/1ps
module smc_top
  import smc_pkg::*;
#(
  parameter int P_LONG_CYC  = smc_pkg::PULSE_LONG_CYC,
  parameter int P_SHORT_CYC = smc_pkg::PULSE_SHORT_CYC
) (
  input  wire logic                       I_CLK,
  input  wire logic                       I_NRST,
  input  wire logic                       I_SCLK,
  input  wire logic                       I_CS_N,
  input  wire logic                       I_MOSI,
  output logic                            O_MISO,
  input  wire logic                       I_INT_EVENT,
  input  wire logic                       I_INT_ACK,
  input  wire logic                       I_PROG_WATCH,
  input  wire logic                       I_WD_HALF,
  input  wire logic                       I_LP_REQ,
  input  wire logic [2:0]                 I_LP_CODE,
  input  wire logic [2:0]                 I_LP_EXPECT,
  output logic                            O_LP_GRANT,
  output logic                            O_LP_REJECT,
  output logic                            O_INT_N,
  output logic                            O_PARITY_ERR,
  output logic [smc_pkg::CFG_W-1:0]       O_CFG,
  output logic                            O_RES_CHECK_EN,
  output logic [1:0]                      O_RES_EXPECT,
  output logic [1:0]                      O_SAFE_VARIANT
);
  import smc_pkg::*;

  // ----------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------
  logic       rst_a_q;
  logic       rst_n;
  logic [2:0] pin_a_q;
  logic [2:0] pin_b_q;
  logic       sclk_old_q;
  logic       cs_old_q;

  // reset asserts at once, releases after two edges
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_a_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n   <= rst_a_q;
    end
  end

  // first stage feeds only the second stage
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_q    <= 3'h1;
      pin_b_q    <= 3'h1;
      sclk_old_q <= 1'b0;
      cs_old_q   <= 1'b1;
    end else begin
      pin_a_q    <= {I_MOSI, I_SCLK, I_CS_N};
      pin_b_q    <= pin_a_q;
      sclk_old_q <= pin_b_q[1];
      cs_old_q   <= pin_b_q[0];
    end
  end

  logic mosi_s;
  logic sclk_s;
  logic cs_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  // edges seen on the synchronised copies only
  always_comb begin
    mosi_s    = pin_b_q[2];
    sclk_s    = pin_b_q[1];
    cs_n_s    = pin_b_q[0];
    sclk_rise = sclk_s & ~sclk_old_q & ~cs_n_s;
    sclk_fall = ~sclk_s & sclk_old_q & ~cs_n_s;
    cs_fall   = ~cs_n_s & cs_old_q;
    cs_rise   = cs_n_s & ~cs_old_q;
  end

  // ----------------------------------------------------------
  // spi frame capture and register write
  // ----------------------------------------------------------
  logic [FRAME_W-1:0] rx_q,   rx_d;
  logic [FRAME_W-1:0] tx_q,   tx_d;
  logic [4:0]         cnt_q,  cnt_d;
  logic [CFG_W-1:0]   cfg_q,  cfg_d;
  logic               perr_q, perr_d;
  logic               miso_q, miso_d;
  logic               frame_ok;
  logic               parity_ok;

  // a frame shorter than sixteen bits is dropped whole; a longer one keeps its last sixteen bits
  always_comb begin
    rx_d      = rx_q;
    tx_d      = tx_q;
    cnt_d     = cnt_q;
    cfg_d     = cfg_q;
    perr_d    = 1'b0;
    miso_d    = miso_q;
    // even parity over the whole frame; the host zeroes the bit when unused
    parity_ok = ~(^rx_q);
    frame_ok  = (cnt_q == BITS_FULL) && rx_q[FB_WRITE]
                && (rx_q[FB_ADDR_HI:FB_ADDR_LO] == CFG_ADDR);
    if (cs_fall) begin
      cnt_d  = 5'h00;
      tx_d   = {7'h00, perr_q, cfg_q};
      miso_d = 1'b0;
    end else if (sclk_rise) begin
      rx_d = {rx_q[FRAME_W-2:0], mosi_s};
      if (cnt_q != BITS_FULL) begin
        cnt_d = cnt_q + 5'h01;
      end
    end else if (sclk_fall) begin
      miso_d = tx_q[FRAME_W-1];
      tx_d   = {tx_q[FRAME_W-2:0], 1'b0};
    end
    if (cs_rise && frame_ok) begin
      if (!cfg_q[BIT_PARITY] || parity_ok) begin
        cfg_d = rx_q[CFG_W-1:0];
      end else begin
        perr_d = 1'b1;
      end
    end
  end

  // spi state registers
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_q   <= '0;
      tx_q   <= '0;
      cnt_q  <= 5'h00;
      cfg_q  <= CFG_RESET;
      perr_q <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      rx_q   <= rx_d;
      tx_q   <= tx_d;
      cnt_q  <= cnt_d;
      cfg_q  <= cfg_d;
      perr_q <= perr_d;
      miso_q <= miso_d;
    end
  end

  // ----------------------------------------------------------
  // interrupt output shaping
  // ----------------------------------------------------------
  smc_int_e           st_q,   st_d;
  logic [CNT_W-1:0]   tmr_q,  tmr_d;
  logic               intn_q, intn_d;
  logic               trig;

  // a new event during a pulse is merged into it rather than queued
  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    trig   = I_INT_EVENT
             || (I_WD_HALF && I_PROG_WATCH && cfg_q[BIT_HALF_WD]);
    unique case (st_q)
      INT_IDLE: begin
        if (trig && cfg_q[BIT_LEVEL]) begin
          st_d = INT_LEVEL;
        end else if (trig) begin
          st_d  = INT_PULSE;
          tmr_d = cfg_q[BIT_SHORT] ? CNT_W'(P_SHORT_CYC - 1)
                                   : CNT_W'(P_LONG_CYC - 1);
        end
      end
      INT_PULSE: begin
        if (tmr_q == '0) begin
          st_d = INT_IDLE;
        end else begin
          tmr_d = tmr_q - CNT_W'(1);
        end
      end
      INT_LEVEL: begin
        // the event wins over an acknowledge in the same cycle
        if (I_INT_ACK && !trig) begin
          st_d = INT_IDLE;
        end
      end
    endcase
    intn_d = (st_d == INT_IDLE);
  end

  // interrupt registers
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= INT_IDLE;
      tmr_q  <= '0;
      intn_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      intn_q <= intn_d;
    end
  end

  // ----------------------------------------------------------
  // low-power entry check and resistor code decode
  // ----------------------------------------------------------
  logic       grant_q, grant_d;
  logic       rej_q,   rej_d;
  logic       chk_q,   chk_d;
  logic [1:0] exp_q,   exp_d;
  logic [1:0] safe_q,  safe_d;

  // outputs registered so the pins never see decode glitches
  always_comb begin
    grant_d = 1'b0;
    rej_d   = 1'b0;
    if (I_LP_REQ) begin
      if (!cfg_q[BIT_KEYED_LP] || (I_LP_CODE == I_LP_EXPECT)) begin
        grant_d = 1'b1;
      end else begin
        rej_d = 1'b1;
      end
    end
    chk_d  = 1'b0;
    exp_d  = EXPECT_NONE;
    safe_d = SAFE_NONE;
    unique case (cfg_q[RES_HI:RES_LO])
      RES_LARGE: begin
        chk_d  = 1'b1;
        exp_d  = EXPECT_LARGE;
        safe_d = SAFE_THREE;
      end
      RES_MIDDLE: begin
        chk_d  = 1'b1;
        exp_d  = EXPECT_MID;
        safe_d = SAFE_TWO;
      end
      RES_SMALL: begin
        chk_d  = 1'b1;
        exp_d  = EXPECT_SMALL;
        safe_d = SAFE_ONE;
      end
      default: begin
        chk_d  = 1'b0;
      end
    endcase
  end

  // decode registers
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      grant_q <= 1'b0;
      rej_q   <= 1'b0;
      chk_q   <= 1'b0;
      exp_q   <= EXPECT_NONE;
      safe_q  <= SAFE_NONE;
    end else begin
      grant_q <= grant_d;
      rej_q   <= rej_d;
      chk_q   <= chk_d;
      exp_q   <= exp_d;
      safe_q  <= safe_d;
    end
  end

  // ----------------------------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------------------------
  always_comb begin
    O_MISO         = miso_q;
    O_LP_GRANT     = grant_q;
    O_LP_REJECT    = rej_q;
    O_INT_N        = intn_q;
    O_PARITY_ERR   = perr_q;
    O_CFG          = cfg_q;
    O_RES_CHECK_EN = chk_q;
    O_RES_EXPECT   = exp_q;
    O_SAFE_VARIANT = safe_q;
  end

endmodule

/* File: tb/smc_sva.sv */
// port-level assertions for the configuration register block
`timescale 1ns/1ps
module smc_sva
  import smc_pkg::*;
#(
  parameter int P_LONG_CYC  = smc_pkg::PULSE_LONG_CYC,
  parameter int P_SHORT_CYC = smc_pkg::PULSE_SHORT_CYC
) (
  input wire logic       I_CLK,
  input wire logic       I_NRST,
  input wire logic       I_INT_EVENT,
  input wire logic       I_INT_ACK,
  input wire logic       I_PROG_WATCH,
  input wire logic       I_WD_HALF,
  input wire logic       I_LP_REQ,
  input wire logic [2:0] I_LP_CODE,
  input wire logic [2:0] I_LP_EXPECT,
  input wire logic       O_LP_GRANT,
  input wire logic       O_LP_REJECT,
  input wire logic       O_INT_N,
  input wire logic       O_PARITY_ERR,
  input wire logic [7:0] O_CFG,
  input wire logic       O_RES_CHECK_EN,
  input wire logic [1:0] O_RES_EXPECT,
  input wire logic [1:0] O_SAFE_VARIANT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic [15:0] low_q;
  // cycles the interrupt line has been low, cleared while high; wide enough for the long pulse
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) low_q <= 16'h0000;
    else low_q <= O_INT_N ? 16'h0000 : low_q + 16'h0001;
  end
  // decode outputs lag the register by one cycle, so wait two stable samples
  sequence cfg_settled;
    $stable(O_CFG) [*2];
  endsequence
  lp_open_a: assert property (I_LP_REQ && !O_CFG[7] |=> O_LP_GRANT && !O_LP_REJECT)
    else $error("open low power request not granted");
  lp_key_a: assert property (I_LP_REQ && O_CFG[7] |=> O_LP_REJECT != O_LP_GRANT
    && O_LP_GRANT == ($past(I_LP_CODE) == $past(I_LP_EXPECT))) else $error("keyed request answered wrongly");
  int_start_a: assert property (I_INT_EVENT && O_INT_N |=> !O_INT_N)
    else $error("interrupt not raised");
  int_hold_a: assert property (O_CFG[5] && !O_INT_N && !I_INT_ACK |=> !O_INT_N)
    else $error("level interrupt released without ack");
  // the line stays low for exactly the programmed number of cycles
  int_width_a: assert property ($rose(O_INT_N) && !O_CFG[5] && low_q != 16'h0000
    |-> low_q == 16'(O_CFG[4] ? P_SHORT_CYC : P_LONG_CYC)) else $error("pulse width wrong");
  half_wd_a: assert property (O_INT_N && I_WD_HALF && I_PROG_WATCH && O_CFG[3] |=> !O_INT_N)
    else $error("half period pulse missing");
  no_half_a: assert property (O_INT_N && !I_INT_EVENT && !(I_WD_HALF && I_PROG_WATCH && O_CFG[3]) |=> O_INT_N)
    else $error("interrupt without cause");
  res_off_a: assert property (cfg_settled |-> O_CFG[2] || {O_RES_CHECK_EN, O_RES_EXPECT, O_SAFE_VARIANT} == 5'h00)
    else $error("resistor check not disabled");
  res_large_a: assert property (cfg_settled ##0 O_CFG[2:0] == RES_LARGE |-> O_RES_CHECK_EN
    && O_RES_EXPECT == EXPECT_LARGE && O_SAFE_VARIANT == SAFE_THREE) else $error("large code decode wrong");
  res_mid_a: assert property (cfg_settled ##0 O_CFG[2:0] == RES_MIDDLE |-> O_RES_CHECK_EN
    && O_RES_EXPECT == EXPECT_MID && O_SAFE_VARIANT == SAFE_TWO) else $error("middle code decode wrong");
  res_small_a: assert property (cfg_settled ##0 O_CFG[2:0] == RES_SMALL |-> O_RES_CHECK_EN
    && O_RES_EXPECT == EXPECT_SMALL && O_SAFE_VARIANT == SAFE_ONE) else $error("small code decode wrong");
  par_drop_a: assert property (O_PARITY_ERR |-> O_CFG[6] && $stable(O_CFG))
    else $error("bad parity write applied");
endmodule
bind smc_top smc_sva #(.P_LONG_CYC(P_LONG_CYC), .P_SHORT_CYC(P_SHORT_CYC)) smc_sva_inst (
  .I_CLK          (I_CLK),
  .I_NRST         (I_NRST),
  .I_INT_EVENT    (I_INT_EVENT),
  .I_INT_ACK      (I_INT_ACK),
  .I_PROG_WATCH   (I_PROG_WATCH),
  .I_WD_HALF      (I_WD_HALF),
  .I_LP_REQ       (I_LP_REQ),
  .I_LP_CODE      (I_LP_CODE),
  .I_LP_EXPECT    (I_LP_EXPECT),
  .O_LP_GRANT     (O_LP_GRANT),
  .O_LP_REJECT    (O_LP_REJECT),
  .O_INT_N        (O_INT_N),
  .O_PARITY_ERR   (O_PARITY_ERR),
  .O_CFG          (O_CFG),
  .O_RES_CHECK_EN (O_RES_CHECK_EN),
  .O_RES_EXPECT   (O_RES_EXPECT),
  .O_SAFE_VARIANT (O_SAFE_VARIANT)
);

/* File: tb/smc_host.sv */
// spi master model standing in for the host controller
`timescale 1ns/1ps
module smc_host
  import smc_pkg::*;
(
  input  wire logic clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  // clock idles low and stands still between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one frame msb first; miso is taken before each rise and once before deselect
  task automatic xfer(input logic [15:0] f, output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = f[i];
      hold(6);
      r = {r[14:0], miso};
      sclk = 1'b1;
      hold(6);
      sclk = 1'b0;
    end
    hold(6);
    r = {r[14:0], miso};
    cs_n = 1'b1;
    mosi = ~mosi;  // released line shows the opposite of its last bit
    hold(4);
  endtask
  // parity bit is zero when unused, else makes the frame even; bad flips it
  task automatic write_cfg(input logic [7:0] d, input logic par_on, input logic bad, output logic [15:0] r);
    logic p;
    p = (par_on ? ^{1'b1, CFG_ADDR, d} : 1'b0) ^ bad;
    xfer({1'b1, CFG_ADDR, p, d}, r);
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the configuration register block
`timescale 1ns/1ps
module testbench;
  import smc_pkg::*;
  localparam int LONG = 40;
  localparam int SHORT = 10;
  logic clk, rst_n, sclk, cs_n, mosi, miso, evt, ack, prog, half, lp_req, grant, reject, int_n, perr, res_en;
  logic [2:0] lp_code, lp_exp;
  logic [7:0] cfg;
  logic [1:0] res_exp, safe;
  logic [15:0] rd;
  logic perr_seen = 1'b0;
  logic [7:0] tbl [5] = '{8'h9F, 8'hBA, 8'hD5, 8'h60, 8'hE0};
  int fails, n_compared, cyc = 0;
  smc_top #(.P_LONG_CYC(LONG), .P_SHORT_CYC(SHORT)) smc_top_inst (
    .I_CLK(clk), .I_NRST(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n), .I_MOSI(mosi), .O_MISO(miso),
    .I_INT_EVENT(evt), .I_INT_ACK(ack), .I_PROG_WATCH(prog), .I_WD_HALF(half), .I_LP_REQ(lp_req),
    .I_LP_CODE(lp_code), .I_LP_EXPECT(lp_exp), .O_LP_GRANT(grant), .O_LP_REJECT(reject), .O_INT_N(int_n),
    .O_PARITY_ERR(perr), .O_CFG(cfg), .O_RES_CHECK_EN(res_en), .O_RES_EXPECT(res_exp), .O_SAFE_VARIANT(safe));
  smc_host smc_host_inst (.clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // -------------------------------------------------------
  // helpers
  // -------------------------------------------------------
  // error pulse lasts one cycle, so latch it; ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (perr === 1'b1) perr_seen <= 1'b1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wr(input logic [7:0] d, input logic par_on, input logic bad);
    smc_host_inst.write_cfg(d, par_on, bad, rd);
    tick(8);
  endtask
  task automatic rd_cfg();
    smc_host_inst.xfer({1'b0, CFG_ADDR, 9'h000}, rd);
  endtask
  task automatic lp(input logic [2:0] c, input logic [2:0] e, input logic g);
    lp_req = 1'b1;
    lp_code = c;
    lp_exp = e;
    tick(1);
    chk({14'h0, grant, reject}, {14'h0, g, !g});
    // let an edge pass so a following request is a fresh one
    lp_req = 1'b0;
    tick(1);
  endtask
  // interrupt low time counted from the cycle after the trigger
  task automatic pulse_len(input logic [7:0] c, input int exp);
    int n;
    n = 0;
    wr(c, 1'b1, 1'b0);
    evt = 1'b1;
    tick(1);
    evt = 1'b0;
    while (int_n === 1'b0 && n < 200) begin
      n++;
      tick(1);
    end
    chk(n[15:0], exp[15:0]);
  endtask
  task automatic conclude();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial begin
    {rst_n, evt, ack, prog, half, lp_req} = 6'h00;
    {lp_code, lp_exp} = 6'h00;
    fails = 0;
    n_compared = 0;
    tick(12);
    rst_n = 1'b1;
    tick(6);
    chk({8'h00, cfg}, {8'h00, CFG_RESET});
    chk({13'h0, int_n, res_en, perr}, 16'h0004);
    lp(3'h5, 3'h2, 1'b1);
    done("reset");
    wr(8'hC4, 1'b0, 1'b0);
    chk({8'h00, cfg}, 16'h00C4);
    rd_cfg();
    chk({8'h00, rd[7:0]}, 16'h00C4);
    lp(3'h3, 3'h3, 1'b1);
    lp(3'h3, 3'h4, 1'b0);
    done("keyed low power");
    wr(8'h46, 1'b1, 1'b1);
    chk({7'h00, perr_seen, cfg}, 16'h01C4);
    for (int i = 0; i < 5; i++) begin
      wr({5'h08, tbl[i][7:5]}, 1'b1, 1'b0);
      chk({res_en, res_exp, safe, cfg}, {tbl[i][4:0], 5'h08, tbl[i][7:5]});
    end
    done("parity and resistor codes");
    pulse_len(8'h40, LONG);
    pulse_len(8'h50, SHORT);
    wr(8'h60, 1'b1, 1'b0);
    evt = 1'b1;
    tick(1);
    evt = 1'b0;
    tick(LONG + 10);
    chk({15'h0, int_n}, 16'h0000);
    ack = 1'b1;
    tick(1);
    ack = 1'b0;
    tick(1);
    chk({15'h0, int_n}, 16'h0001);
    done("interrupt shapes");
    prog = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(i ? 8'h50 : 8'h58, 1'b1, 1'b0);
      half = 1'b1;
      tick(1);
      half = 1'b0;
      tick(1);
      chk({15'h0, int_n}, {15'h0, i[0]});
      tick(SHORT + 4);
    end
    done("half period pulse");
    conclude();
  end
endmodule
